//--- core/hdt_fifo.sv
// Byte FIFO with optional overwrite of the newest entry when full
`timescale 1ns/1ns
module hdt_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 19,
  parameter bit OVERWRITE = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  input wire logic rd,
  output logic [W-1:0] rdata,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [CW-1:0] cnt;
  logic do_rd;
  logic do_wr;
  logic ovw;

  generate
    if (DEPTH < 2) begin : g_bad
      $error("hdt_fifo needs DEPTH of at least 2");
    end
  endgenerate

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign do_rd = rd && !empty;
  assign do_wr = wr && (!full || do_rd);
  // Full and no read: the newest slot takes the byte instead
  assign ovw = OVERWRITE && wr && full && !do_rd;
  assign rdata = mem[rp];
  assign empty = (cnt == '0);
  assign full = (cnt == CW'(DEPTH));

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp] <= wdata;
    end else if (ovw) begin
      mem[(wp == '0) ? AW'(DEPTH - 1) : wp - 1'b1] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (do_wr) begin
        wp <= nxt(wp);
      end
      if (do_rd) begin
        rp <= nxt(rp);
      end
      if (do_wr && !do_rd) begin
        cnt <= cnt + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule // hdt_fifo

//--- core/hdt_pkg.sv
// Shared constants, types and the check function of the D-channel framer
package hdt_pkg;
  localparam logic [7:0] HDT_CTRL1 = 8'h00;
  localparam logic [7:0] HDT_CTRL2 = 8'h04;
  localparam logic [7:0] HDT_STATUS = 8'h08;
  localparam logic [7:0] HDT_IMASK = 8'h0c;
  localparam logic [7:0] HDT_ISTAT = 8'h10;
  localparam logic [7:0] HDT_FIFO = 8'h14;
  localparam logic [7:0] HDT_ADDR1 = 8'h18;
  localparam logic [7:0] HDT_ADDR2 = 8'h1c;
  localparam int C1_TX_ON = 0;
  localparam int C1_RX_ON = 1;
  localparam int C1_FILL = 2;
  localparam int C1_AFE = 3;
  localparam int C1_A2 = 4;
  localparam int C2_LAST = 0;
  localparam int C2_ABT = 1;
  localparam int C2_TRANS = 4;
  localparam int IS_RXB = 0;
  localparam int IS_EOPD = 1;
  localparam int IS_RX_ABORT = 2;
  localparam int IS_TX_DONE = 3;
  localparam int IS_TUR = 4;
  localparam logic [4:0] CTRL1_RST = 5'h00;
  localparam logic [4:0] CTRL2_RST = 5'h00;
  localparam logic [4:0] IMASK_RST = 5'h00;
  localparam logic [1:0] TAG_MID = 2'h0;
  localparam logic [1:0] TAG_FIRST = 2'h1;
  localparam logic [1:0] TAG_GOOD = 2'h2;
  localparam logic [1:0] TAG_BAD = 2'h3;
  localparam logic [7:0] HDT_FLAG = 8'h7e;
  localparam logic [7:0] HDT_ABORT = 8'hfe;
  localparam logic [7:0] HDT_ONES = 8'hff;
  localparam logic [15:0] HDT_CRC_POLY = 16'h8408;
  localparam logic [15:0] HDT_CRC_INIT = 16'hffff;
  localparam logic [15:0] HDT_CRC_GOOD = 16'hf0b8;
  localparam logic [3:0] HDT_STUFF_RUN = 4'h5;
  localparam logic [3:0] HDT_FLAG_RUN = 4'h6;
  localparam logic [3:0] HDT_IDLE_RUN = 4'hf;
  localparam int HDT_FIFO_DEPTH = 19;
  localparam int HDT_CLK_PERIOD_NS = 10;
  localparam int HDT_BIT_PERIOD_NS = 62500;
  localparam int HDT_BIT_CYCLES = HDT_BIT_PERIOD_NS / HDT_CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    TX_ONES = 6'b000001,
    TX_FLAG = 6'b000010,
    TX_DATA = 6'b000100,
    TX_FCS = 6'b001000,
    TX_ABORT = 6'b010000,
    TX_RAW = 6'b100000
  } hdt_tx_t;

  // Reflected form: bits enter LSB first, check leaves MSB first
  function automatic logic [15:0] hdt_crc_step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    hdt_crc_step = {1'b0, c[15:1]} ^ (fb ? HDT_CRC_POLY : 16'h0000);
  endfunction
endpackage

//--- core/hdt_top.sv
// D-channel bit-oriented framer with AHB-Lite register access
// Summary of operation
// - Check field is 16 bits after data, generator x^16+x^12+x^5+1.
// - Transmit check covers data bits, sent inverted, most significant bit first.
// - Receiver checks data plus check field for fixed residue; result in status 7:6.
// - Transmitter stuffs a zero after five ones in data and check bits.
// - Receiver drops any zero following five ones inside a frame.
// - Abort request tags next byte; tagged byte sent as abort once packet has two or more bytes.
// - Seven or more ones inside a frame abort it and raise a frame-abort event.
// - Idle status sets after fifteen ones and clears when a flag arrives.
// - Between packets send ones or flags per fill select; leave when data queued.
// - After reset transmitter idles on ones until transmit enable is set.
// - Transmit FIFO holds 19 bytes, written one at a time, address first.
// - From ones idle finish byte then flag; from flag fill reuse current flag.
// - End-of-packet bit tags next byte, self-clears; then check bits and closing flag.
// - FIFO empty after an untagged byte sends abort, then returns to fill.
// - Writing a full transmit FIFO replaces the newest byte.
// - Transparent bit 4 sends FIFO bytes raw with no framing, stuffing or check.
// - After reset receiver, address filter and interrupts are off.
// - Reading interrupt status clears every pending interrupt.
// - Receiver realigns on each flag; stores data bytes only, 19-byte FIFO.
// - Address filter: top six bits or two bytes, all-call matches, misses dropped.
// - Each received byte carries a first, middle, good-last or bad-last tag.
// - Flag is 01111110, sent by transmitter, searched bit by bit by receiver.
`timescale 1ns/1ns
module hdt_top
  import hdt_pkg::*;
#(
  parameter int BIT_DIV = hdt_pkg::HDT_BIT_CYCLES,
  parameter int DEPTH = hdt_pkg::HDT_FIFO_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rx_data,
  output logic tx_data,
  output logic irq
);
  import hdt_pkg::*;

  generate
    if (BIT_DIV < 2 || BIT_DIV > 65535 || DEPTH < 2) begin : g_bad
      $error("hdt_top: BIT_DIV or DEPTH out of range");
    end
  endgenerate

  logic [4:0] ctrl1;
  logic [4:0] ctrl2;
  logic [4:0] imask;
  logic [4:0] istat;
  logic [7:0] addr1;
  logic [7:0] addr2;
  logic a_act;
  logic a_wr;
  logic a_map;
  logic [7:0] a_adr;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_mux;
  logic [15:0] bit_cnt;
  logic bit_en;
  logic rx_s1;
  logic rx_s2;
  logic trans;
  logic [9:0] tf_head;
  logic tf_empty;
  logic tf_full;
  logic tx_push;
  logic tx_pop;
  logic [9:0] rf_head;
  logic rf_empty;
  logic rx_pop;
  logic rx_wr;
  logic [9:0] rx_wdat;
  hdt_tx_t tx_st;
  logic [15:0] tx_sh;
  logic [4:0] tx_left;
  logic [3:0] tx_ones;
  logic [15:0] tx_crc;
  logic [15:0] tx_crc_n;
  logic [1:0] tx_pkt;
  logic tx_last;
  logic tx_go;
  logic fill_flag;
  logic ev_transmit_packet_done_irq;
  logic ev_tur;
  logic [3:0] rx_ones;
  logic rx_idle;
  logic rx_inf;
  logic [6:0] rx_dl;
  logic [2:0] rx_dln;
  logic [7:0] rx_sr;
  logic [2:0] rx_bits;
  logic [15:0] rx_crc;
  logic [7:0] rx_p0;
  logic [7:0] rx_p1;
  logic [7:0] rx_p2;
  logic [1:0] rx_pn;
  logic [1:0] rx_nb;
  logic rx_first;
  logic ev_eopd;
  logic ev_rab;
  logic rx_flag;
  logic rx_abt;
  logic rx_run7;
  logic rx_stuf;
  logic rx_push;
  logic [7:0] rx_byte;
  logic rx_allc;
  logic a_ok;

  // Bus side: one wait state so read data can come from a flop
  assign wr_go = a_act && a_wr && a_map;
  assign rd_go = a_act && !a_wr && a_map;
  assign tx_push = wr_go && (a_adr == HDT_FIFO);
  assign rx_pop = rd_go && (a_adr == HDT_FIFO);
  assign trans = ctrl2[C2_TRANS];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_act <= 1'b0;
      a_wr <= 1'b0;
      a_map <= 1'b0;
      a_adr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        a_act <= 1'b1;
        a_wr <= hwrite;
        a_map <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
        a_adr <= haddr[7:0];
        hreadyout <= 1'b0;
      end else if (a_act) begin
        a_act <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (a_adr == HDT_CTRL1) begin
      rd_mux[4:0] = ctrl1;
    end else if (a_adr == HDT_CTRL2) begin
      rd_mux[4:0] = ctrl2;
    end else if (a_adr == HDT_STATUS) begin
      rd_mux[7:0] = {rf_head[9:8], rx_idle, !rf_empty, tf_full, tf_empty, 2'h0};
    end else if (a_adr == HDT_IMASK) begin
      rd_mux[4:0] = imask;
    end else if (a_adr == HDT_ISTAT) begin
      rd_mux[4:0] = istat;
    end else if (a_adr == HDT_FIFO) begin
      rd_mux[7:0] = rf_empty ? 8'h00 : rf_head[7:0];
    end else if (a_adr == HDT_ADDR1) begin
      rd_mux[7:0] = addr1;
    end else if (a_adr == HDT_ADDR2) begin
      rd_mux[7:0] = addr2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (a_act && !a_wr) begin
      hrdata <= a_map ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1 <= CTRL1_RST;
      ctrl2 <= CTRL2_RST;
      imask <= IMASK_RST;
      addr1 <= 8'h00;
      addr2 <= 8'h00;
    end else if (wr_go) begin
      if (a_adr == HDT_CTRL1) begin
        ctrl1 <= hwdata[4:0];
      end else if (a_adr == HDT_CTRL2) begin
        ctrl2 <= {hwdata[4], 2'h0, hwdata[1:0]};
      end else if (a_adr == HDT_IMASK) begin
        imask <= hwdata[4:0];
      end else if (a_adr == HDT_ADDR1) begin
        addr1 <= hwdata[7:0];
      end else if (a_adr == HDT_ADDR2) begin
        addr2 <= hwdata[7:0];
      end else if (a_adr == HDT_FIFO) begin
        ctrl2[C2_LAST] <= 1'b0;
        ctrl2[C2_ABT] <= 1'b0;
      end
    end
  end

  // New events win over the clear caused by the status read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat <= 5'h00;
      irq <= 1'b0;
    end else begin
      istat <= ((rd_go && a_adr == HDT_ISTAT) ? 5'h00 : istat)
        | {ev_tur, ev_transmit_packet_done_irq, ev_rab, ev_eopd, rx_wr};
      irq <= |(istat & imask);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt <= 16'h0000;
      bit_en <= 1'b0;
    end else begin
      bit_en <= (bit_cnt == 16'(BIT_DIV - 1));
      bit_cnt <= (bit_cnt == 16'(BIT_DIV - 1)) ? 16'h0000 : bit_cnt + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= rx_data;
      rx_s2 <= rx_s1;
    end
  end

  hdt_fifo #(.W(10), .DEPTH(DEPTH), .OVERWRITE(1'b1)) u_txf (
    .clk(hclk),
    .rst_n(hresetn),
    .wr(tx_push),
    .wdata({ctrl2[C2_ABT], ctrl2[C2_LAST], hwdata[7:0]}),
    .rd(tx_pop),
    .rdata(tf_head),
    .empty(tf_empty),
    .full(tf_full)
  );

  hdt_fifo #(.W(10), .DEPTH(DEPTH), .OVERWRITE(1'b0)) u_rxf (
    .clk(hclk),
    .rst_n(hresetn),
    .wr(rx_wr),
    .wdata(rx_wdat),
    .rd(rx_pop),
    .rdata(rf_head),
    .empty(rf_empty),
    .full()
  );

  // Transmitter: shift register sent LSB first, one bit per bit_en
  assign tx_crc_n = hdt_crc_step(tx_crc, tx_sh[0]);
  assign tx_go = ctrl1[C1_TX_ON] && !tf_empty;
  assign fill_flag = ctrl1[C1_TX_ON] && ctrl1[C1_FILL];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st <= TX_ONES;
      tx_sh <= {8'h00, HDT_ONES};
      tx_left <= 5'd8;
      tx_ones <= 4'h0;
      tx_crc <= HDT_CRC_INIT;
      tx_pkt <= 2'h0;
      tx_last <= 1'b0;
      tx_data <= 1'b1;
      tx_pop <= 1'b0;
      ev_transmit_packet_done_irq <= 1'b0;
      ev_tur <= 1'b0;
    end else begin
      tx_pop <= 1'b0;
      ev_transmit_packet_done_irq <= 1'b0;
      ev_tur <= 1'b0;
      if (bit_en) begin
        if (tx_ones == HDT_STUFF_RUN) begin
          tx_data <= 1'b0;
          tx_ones <= 4'h0;
        end else begin
          tx_data <= tx_sh[0];
          tx_sh <= {1'b0, tx_sh[15:1]};
          tx_left <= tx_left - 5'd1;
          if (tx_st == TX_DATA || tx_st == TX_FCS) begin
            tx_ones <= tx_sh[0] ? tx_ones + 4'h1 : 4'h0;
          end else begin
            tx_ones <= 4'h0;
          end
          if (tx_st == TX_DATA) begin
            tx_crc <= tx_crc_n;
          end
          if (tx_left == 5'd1) begin
            case (tx_st)
              TX_ONES, TX_RAW, TX_FLAG: begin
                if (tx_go && trans) begin
                  tx_st <= TX_RAW;
                  tx_sh <= {8'h00, tf_head[7:0]};
                  tx_left <= 5'd8;
                  tx_pop <= 1'b1;
                end else if (tx_go && tx_st == TX_FLAG) begin
                  tx_st <= TX_DATA;
                  tx_sh <= {8'h00, tf_head[7:0]};
                  tx_left <= 5'd8;
                  tx_pop <= 1'b1;
                  tx_last <= tf_head[8];
                  tx_crc <= HDT_CRC_INIT;
                  tx_pkt <= 2'h1;
                end else if (tx_go && tx_st == TX_ONES) begin
                  tx_st <= TX_FLAG;
                  tx_sh <= {8'h00, HDT_FLAG};
                  tx_left <= 5'd8;
                end else begin
                  tx_st <= fill_flag ? TX_FLAG : TX_ONES;
                  tx_sh <= {8'h00, fill_flag ? HDT_FLAG : HDT_ONES};
                  tx_left <= 5'd8;
                end
              end
              TX_DATA: begin
                if (tx_last) begin
                  tx_st <= TX_FCS;
                  tx_sh <= ~tx_crc_n;
                  tx_left <= 5'd16;
                end else if (tf_empty) begin
                  tx_st <= TX_ABORT;
                  tx_sh <= {8'h00, HDT_ABORT};
                  tx_left <= 5'd8;
                  ev_tur <= 1'b1;
                end else if (tf_head[9] && tx_pkt == 2'h2) begin
                  tx_st <= TX_ABORT;
                  tx_sh <= {8'h00, HDT_ABORT};
                  tx_left <= 5'd8;
                  tx_pop <= 1'b1;
                end else begin
                  tx_sh <= {8'h00, tf_head[7:0]};
                  tx_left <= 5'd8;
                  tx_pop <= 1'b1;
                  tx_last <= tf_head[8];
                  tx_pkt <= 2'h2;
                end
              end
              TX_FCS: begin
                tx_st <= TX_FLAG;
                tx_sh <= {8'h00, HDT_FLAG};
                tx_left <= 5'd8;
                ev_transmit_packet_done_irq <= 1'b1;
              end
              default: begin
                tx_st <= fill_flag ? TX_FLAG : TX_ONES;
                tx_sh <= {8'h00, fill_flag ? HDT_FLAG : HDT_ONES};
                tx_left <= 5'd8;
              end
            endcase
          end
        end
      end
    end
  end

  // Receiver: data bits pass a 7-bit delay so a closing flag never lands in a byte
  assign rx_flag = !rx_s2 && (rx_ones == HDT_FLAG_RUN);
  // Ones after a closing flag are idle, not an abort: only a frame with content aborts
  assign rx_run7 = rx_s2 && (rx_ones >= HDT_FLAG_RUN);
  assign rx_abt = rx_run7 && rx_inf && (rx_dln == 3'h7);
  assign rx_stuf = !rx_s2 && (rx_ones == HDT_STUFF_RUN);
  assign rx_push = rx_inf && !rx_flag && !rx_run7 && !rx_stuf;
  assign rx_byte = {rx_dl[0], rx_sr[7:1]};
  assign rx_allc = (rx_byte[7:1] == 7'h7f);
  always_comb begin
    a_ok = 1'b1;
    if (ctrl1[C1_AFE] && rx_nb == 2'h0) begin
      a_ok = ctrl1[C1_A2] ? (rx_byte == addr1 || rx_allc)
        : (rx_byte[7:2] == addr1[7:2] || rx_allc);
    end else if (ctrl1[C1_AFE] && ctrl1[C1_A2] && rx_nb == 2'h1) begin
      a_ok = (rx_byte == addr2);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ones <= 4'h0;
      rx_idle <= 1'b0;
      rx_inf <= 1'b0;
      rx_dl <= 7'h00;
      rx_dln <= 3'h0;
      rx_sr <= 8'h00;
      rx_bits <= 3'h0;
      rx_crc <= HDT_CRC_INIT;
      rx_p0 <= 8'h00;
      rx_p1 <= 8'h00;
      rx_p2 <= 8'h00;
      rx_pn <= 2'h0;
      rx_nb <= 2'h0;
      rx_first <= 1'b1;
      rx_wr <= 1'b0;
      rx_wdat <= 10'h000;
      ev_eopd <= 1'b0;
      ev_rab <= 1'b0;
    end else begin
      rx_wr <= 1'b0;
      ev_eopd <= 1'b0;
      ev_rab <= 1'b0;
      if (!ctrl1[C1_RX_ON]) begin
        rx_inf <= 1'b0;
      end else if (bit_en && trans) begin
        rx_sr <= {rx_s2, rx_sr[7:1]};
        rx_bits <= rx_bits + 3'h1;
        if (rx_bits == 3'h7) begin
          rx_wr <= 1'b1;
          rx_wdat <= {TAG_MID, rx_s2, rx_sr[7:1]};
        end
      end else if (bit_en) begin
        if (!rx_s2) begin
          rx_ones <= 4'h0;
        end else if (rx_ones != HDT_IDLE_RUN) begin
          rx_ones <= rx_ones + 4'h1;
        end
        if (rx_s2 && rx_ones == HDT_IDLE_RUN - 4'h1) begin
          rx_idle <= 1'b1;
        end
        if (rx_flag) begin
          rx_idle <= 1'b0;
          if (rx_inf && rx_pn == 2'h3) begin
            rx_wr <= 1'b1;
            rx_wdat <= {(rx_crc == HDT_CRC_GOOD) ? TAG_GOOD : TAG_BAD, rx_p2};
            ev_eopd <= 1'b1;
          end
          rx_inf <= 1'b1;
          rx_dln <= 3'h0;
          rx_bits <= 3'h0;
          rx_crc <= HDT_CRC_INIT;
          rx_pn <= 2'h0;
          rx_nb <= 2'h0;
          rx_first <= 1'b1;
        end else if (rx_abt) begin
          rx_inf <= 1'b0;
          ev_rab <= 1'b1;
          ev_eopd <= 1'b1;
        end else if (rx_push) begin
          rx_dl <= {rx_s2, rx_dl[6:1]};
          if (rx_dln != 3'h7) begin
            rx_dln <= rx_dln + 3'h1;
          end else begin
            rx_sr <= rx_byte;
            rx_crc <= hdt_crc_step(rx_crc, rx_dl[0]);
            rx_bits <= rx_bits + 3'h1;
            if (rx_bits == 3'h7) begin
              rx_p0 <= rx_byte;
              rx_p1 <= rx_p0;
              rx_p2 <= rx_p1;
              if (rx_pn != 2'h3) begin
                rx_pn <= rx_pn + 2'h1;
              end
              if (rx_nb != 2'h3) begin
                rx_nb <= rx_nb + 2'h1;
              end
              if (rx_pn == 2'h3) begin
                rx_wr <= 1'b1;
                rx_wdat <= {rx_first ? TAG_FIRST : TAG_MID, rx_p2};
                rx_first <= 1'b0;
              end
              if (!a_ok) begin
                rx_inf <= 1'b0;
              end
            end
          end
        end
      end
    end
  end
endmodule // hdt_top

//--- verif/hdt_peer.sv
// Remote station that echoes every received line bit straight back
`timescale 1ns/1ns
module hdt_peer (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  // Frames come back bit for bit, flags and order untouched
  always_ff @(posedge clk) begin
    line_out <= line_in;
  end
endmodule // hdt_peer

//--- verif/hdt_props.sv
// Bus, serial-line and interrupt checks for the D-channel framer
`timescale 1ns/1ns
module hdt_props
  import hdt_pkg::*;
#(
  parameter int BIT_DIV = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic rx_data,
  input wire logic tx_data,
  input wire logic irq
);
  import hdt_pkg::*;
  logic taken, dp, dp_w, rd_done, tx_on_ever;
  logic [31:0] dp_a, rd_a;
  logic [4:0] imask;
  assign taken = hsel & htrans[1] & hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp <= 1'b0;
      dp_w <= 1'b0;
      dp_a <= 32'h0;
    end else if (taken) begin
      dp <= 1'b1;
      dp_w <= hwrite;
      dp_a <= haddr;
    end else if (!hreadyout) begin
      dp <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_done <= 1'b0;
      rd_a <= 32'h0;
    end else begin
      rd_done <= dp & !hreadyout & !dp_w;
      rd_a <= dp_a;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_on_ever <= 1'b0;
      imask <= 5'h00;
    end else if (dp && !hreadyout && dp_w) begin
      if (dp_a == 32'(HDT_CTRL1)) tx_on_ever <= tx_on_ever | hwdata[C1_TX_ON];
      if (dp_a == 32'(HDT_IMASK)) imask <= hwdata[4:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_ack;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_one_wait; taken && hreadyout |=> s_ack; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state not exactly one cycle");
  property p_wait_cause; $fell(hreadyout) |-> $past(taken); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait state without a request");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("response not OKAY");
  property p_unmapped; rd_done && (rd_a[31:8] != 0 || rd_a[1:0] != 0) |-> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold; !rd_done |-> $stable(hrdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved between reads");
  // Repetition count written for a bit period of 8 clocks
  property p_bit_stand; $changed(tx_data) |=> $stable(tx_data)[*7]; endproperty
  a_bit_stand: assert property (p_bit_stand) else $error("serial bit shorter than period");
  property p_tx_off; !tx_on_ever |-> tx_data; endproperty
  a_tx_off: assert property (p_tx_off) else $error("line not ones while never enabled");
  property p_irq_masked; imask == 5'h00 && $past(imask) == 5'h00 |-> !irq; endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt while all masked");
endmodule // hdt_props
bind hdt_top hdt_props #(.BIT_DIV(BIT_DIV)) i_hdt_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .rx_data(rx_data), .tx_data(tx_data), .irq(irq));

//--- verif/hdt_top_tb_top.sv
// Self-checking bench: register access, loopback frame, underrun abort
`timescale 1ns/1ns
module hdt_top_tb_top;
  import hdt_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dph_rd = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic hreadyout, hresp, rx_data, tx_data, irq;
  logic [31:0] eq[$], mq[$];
  logic [7:0] exp_b[19];
  int num_errors = 0, samples_checked = 0, seed = 32'hf80e5950, i;
  always #5 hclk = ~hclk;
  hdt_top #(.BIT_DIV(8), .DEPTH(19)) i_hdt_top (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rx_data(rx_data), .tx_data(tx_data), .irq(irq));
  hdt_peer i_hdt_peer (.clk(hclk), .line_in(tx_data), .line_out(rx_data));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic [31:0] e);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    dph_rd <= !w;
    if (!w) begin
      mq.push_back(m);
      eq.push_back(e);
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    dph_rd <= 1'b0;
  endtask
  // Read results are compared where they land, oldest note first
  always @(posedge hclk) begin
    if (dph_rd && hreadyout === 1'b1) begin
      if (eq.size() == 0) chk("unexpected read", hrdata, 32'hx);
      else chk("read data", hrdata & mq.pop_front(), eq.pop_front());
    end
  end
  task automatic wait_irq();
    int n;
    for (n = 0; n < 5000 && irq !== 1'b1; n++) @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h1);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 32'(HDT_CTRL1), 0, 32'h1f, 32'h0);
    bus(0, 32'(HDT_CTRL2), 0, 32'h13, 32'h0);
    bus(0, 32'(HDT_IMASK), 0, 32'h1f, 32'h0);
    bus(0, 32'(HDT_STATUS), 0, 32'h1c, 32'h4);
    bus(0, 32'h100, 0, 32'hffffffff, 32'h0);
    bus(0, 32'h2, 0, 32'hffffffff, 32'h0);
    exp_b[0] = 8'($random(seed));
    bus(1, 32'(HDT_ADDR1), {24'h0, exp_b[0]}, 0, 0);
    bus(0, 32'(HDT_ADDR1), 0, 32'hff, {24'h0, exp_b[0]});
    bus(1, 32'(HDT_IMASK), 32'h1 << IS_TX_DONE, 0, 0);
    bus(1, 32'(HDT_CTRL1), 32'h2, 0, 0);
    // Fifteen bit times of ones plus margin
    repeat (200) @(posedge hclk);
    bus(0, 32'(HDT_STATUS), 0, 32'h20, 32'h20);
    for (i = 0; i < 19; i++) begin
      exp_b[i] = (i % 4 == 1) ? 8'hff : 8'($random(seed));
      if (i == 18) bus(1, 32'(HDT_CTRL2), 32'h1, 0, 0);
      bus(1, 32'(HDT_FIFO), {24'h0, exp_b[i]}, 0, 0);
    end
    bus(0, 32'(HDT_STATUS), 0, 32'h0c, 32'h08);
    exp_b[18] = 8'($random(seed));
    bus(1, 32'(HDT_CTRL2), 32'h1, 0, 0);
    bus(1, 32'(HDT_FIFO), {24'h0, exp_b[18]}, 0, 0);
    bus(1, 32'(HDT_CTRL1), 32'h3, 0, 0);
    wait_irq();
    // Closing flag still travelling back through the peer
    repeat (200) @(posedge hclk);
    for (i = 0; i < 19; i++) begin
      bus(0, 32'(HDT_STATUS), 0, 32'hc0,
        {24'h0, (i == 0) ? TAG_FIRST : (i == 18) ? TAG_GOOD : TAG_MID, 6'h0});
      bus(0, 32'(HDT_FIFO), 0, 32'hff, {24'h0, exp_b[i]});
    end
    bus(0, 32'(HDT_STATUS), 0, 32'h10, 32'h0);
    bus(0, 32'(HDT_ISTAT), 0, 32'h1f, 32'h0b);
    bus(0, 32'(HDT_ISTAT), 0, 32'h1f, 32'h00);
    bus(1, 32'(HDT_IMASK), 32'h1 << IS_TUR, 0, 0);
    bus(1, 32'(HDT_CTRL1), 32'h7, 0, 0);
    for (i = 0; i < 3; i++) bus(1, 32'(HDT_FIFO), 32'($random(seed) & 8'hff), 0, 0);
    wait_irq();
    repeat (200) @(posedge hclk);
    bus(0, 32'(HDT_ISTAT), 0, 32'h16, 32'h16);
    bus(0, 32'(HDT_STATUS), 0, 32'h20, 32'h0);
    repeat (4) @(posedge hclk);
    chk("queue drained", eq.size(), 32'h0);
    final_report();
  end
endmodule // hdt_top_tb_top
